// ===== wts_pkg.sv
// Overview of operation
// - write starts with start condition, address 0110010, direction bit 0
// - pointer byte for a wake-up write has bit 7 and bit 0 set
// - wake-up data goes as a group of three bytes, high byte first; the host stops early on a refused byte
// - wake-up read returns the compare value only while timer-clear is high
// - wake-up read begins with a dummy write, pointer bit 7 clear, bit 0 set
// - repeated start, address with read bit, then bytes arrive msb first
// - last wanted byte gets no acknowledge, then a stop condition
// - stop clears the pointer, so no stop between dummy write and read
// - bus recovery: start, nine clocks with data released, then stop
// - pulses up to two periods rejected; hold a level over 0.438 s
// - wait 0.438 s after timer-clear rises before any serial access
// - after a refused wake-up write wait about half a second
// - at power-up hold timer-clear low at least 500 ms, then release
package wts_pkg;

  localparam int CLK_HZ = 125000000;
  localparam int BUS_HZ = 100000;
  localparam int QTR_CYC = (CLK_HZ + 4 * BUS_HZ - 1) / (4 * BUS_HZ);
  localparam int QTR_W = 10;

  localparam int RST_LOW_MS = 500;
  localparam int SETTLE_US = 438000;
  localparam int RETRY_MS = 500;
  localparam int RST_LOW_CYC = RST_LOW_MS * (CLK_HZ / 1000);
  localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1000000);
  localparam int RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);

  localparam logic [6:0] SLAVE_ADDR = 7'h32;
  localparam logic [7:0] ADDR_WR = {SLAVE_ADDR, 1'b0};
  localparam logic [7:0] ADDR_RD = {SLAVE_ADDR, 1'b1};
  localparam logic [7:0] PTR_WR = 8'h81;
  localparam logic [7:0] PTR_RD = 8'h01;

  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_WAKE = 4'h4;
  localparam logic [3:0] OFF_RDATA = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hC;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_TCLR = 2;
  localparam int ST_INIT = 3;
  localparam logic [23:0] WAKE_RST = 24'h000000;

  typedef enum logic [2:0] {
    WTS_A_START,
    WTS_A_TX,
    WTS_A_RXA,
    WTS_A_RXN,
    WTS_A_STOP,
    WTS_A_END
  } wts_act_t;

  typedef enum logic [2:0] {
    WTS_C_NONE,
    WTS_C_WRWAKE,
    WTS_C_RDWAKE,
    WTS_C_RDTIME,
    WTS_C_RECOV,
    WTS_C_RSTPULSE
  } wts_cmd_t;

  typedef struct packed {
    wts_act_t   act;
    logic [7:0] dat;
  } wts_step_t;

endpackage

// ===== wts_sync.sv
`timescale 1ns/1ps
module wts_sync #(
  parameter logic RST_VAL = 1'b1
)
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);

  logic meta_r;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

// ===== wts_cnt.sv
`timescale 1ns/1ps
module wts_cnt #(
  parameter int W = 32
)
(
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              zero
);

  logic [W-1:0] cnt_r;

  if (W < 2)
  begin : g_bad_w
    $error("counter width too small");
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      cnt_r <= '0;
    else if (load)
      cnt_r <= load_val;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  assign zero = (cnt_r == '0);

endmodule

// ===== wts_host.sv
`timescale 1ns/1ps
module wts_host #(
  parameter int RST_LOW_CYC = wts_pkg::RST_LOW_CYC,
  parameter int SETTLE_CYC  = wts_pkg::SETTLE_CYC,
  parameter int RETRY_CYC   = wts_pkg::RETRY_CYC,
  parameter int QTR_CYC     = wts_pkg::QTR_CYC
)
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        scl_level,
  output logic             scl_drive,
  output logic             scl_oe,
  input  wire logic        sda_level,
  output logic             sda_drive,
  output logic             sda_oe,
  output logic             tclr_n
);

  typedef enum logic [2:0] {
    S_BOOT,
    S_RSTLOW,
    S_SETTLE,
    S_IDLE,
    S_FETCH,
    S_COND,
    S_BIT,
    S_HOLD
  } wts_st_t;

  if (RST_LOW_CYC < 1 || SETTLE_CYC < 1 || RETRY_CYC < 1 || QTR_CYC < 2 || QTR_CYC >= (1 << wts_pkg::QTR_W))
  begin : g_bad_cnt
    $error("wait counts must be at least one cycle");
  end

  function automatic wts_pkg::wts_step_t step_of(
    input wts_pkg::wts_cmd_t c,
    input logic [3:0]        i,
    input logic [23:0]       w
  );
    wts_pkg::wts_step_t s;
    s = '{wts_pkg::WTS_A_END, 8'h00};
    case (c)
      wts_pkg::WTS_C_WRWAKE:
        case (i)
          4'h0: s = '{wts_pkg::WTS_A_START, 8'h00};
          4'h1: s = '{wts_pkg::WTS_A_TX, wts_pkg::ADDR_WR};
          4'h2: s = '{wts_pkg::WTS_A_TX, wts_pkg::PTR_WR};
          4'h3: s = '{wts_pkg::WTS_A_TX, w[23:16]};
          4'h4: s = '{wts_pkg::WTS_A_TX, w[15:8]};
          4'h5: s = '{wts_pkg::WTS_A_TX, w[7:0]};
          4'h6: s = '{wts_pkg::WTS_A_STOP, 8'h00};
          default: s = '{wts_pkg::WTS_A_END, 8'h00};
        endcase
      wts_pkg::WTS_C_RDWAKE:
        case (i)
          4'h0: s = '{wts_pkg::WTS_A_START, 8'h00};
          4'h1: s = '{wts_pkg::WTS_A_TX, wts_pkg::ADDR_WR};
          4'h2: s = '{wts_pkg::WTS_A_TX, wts_pkg::PTR_RD};
          4'h3: s = '{wts_pkg::WTS_A_START, 8'h00};
          4'h4: s = '{wts_pkg::WTS_A_TX, wts_pkg::ADDR_RD};
          4'h5: s = '{wts_pkg::WTS_A_RXA, 8'hFF};
          4'h6: s = '{wts_pkg::WTS_A_RXA, 8'hFF};
          4'h7: s = '{wts_pkg::WTS_A_RXN, 8'hFF};
          4'h8: s = '{wts_pkg::WTS_A_STOP, 8'h00};
          default: s = '{wts_pkg::WTS_A_END, 8'h00};
        endcase
      wts_pkg::WTS_C_RDTIME:
        case (i)
          4'h0: s = '{wts_pkg::WTS_A_START, 8'h00};
          4'h1: s = '{wts_pkg::WTS_A_TX, wts_pkg::ADDR_RD};
          4'h2: s = '{wts_pkg::WTS_A_RXA, 8'hFF};
          4'h3: s = '{wts_pkg::WTS_A_RXA, 8'hFF};
          4'h4: s = '{wts_pkg::WTS_A_RXN, 8'hFF};
          4'h5: s = '{wts_pkg::WTS_A_STOP, 8'h00};
          default: s = '{wts_pkg::WTS_A_END, 8'h00};
        endcase
      wts_pkg::WTS_C_RECOV:
        case (i)
          4'h0: s = '{wts_pkg::WTS_A_START, 8'h00};
          4'h1: s = '{wts_pkg::WTS_A_RXN, 8'hFF};
          4'h2: s = '{wts_pkg::WTS_A_STOP, 8'h00};
          default: s = '{wts_pkg::WTS_A_END, 8'h00};
        endcase
      default: s = '{wts_pkg::WTS_A_END, 8'h00};
    endcase
    return s;
  endfunction

  wts_st_t            st_r;
  wts_pkg::wts_cmd_t  cmd_r;
  wts_pkg::wts_cmd_t  cmd_new;
  wts_pkg::wts_step_t cur_r;
  wts_pkg::wts_step_t nxt_step;
  logic [3:0]         step_r;
  logic [3:0]         bit_cnt_r;
  logic [1:0]         ph_r;
  logic [7:0]         sh_r;
  logic               ack_bit_r;
  logic               nack_pend_r;
  logic               init_pend_r;
  logic               l_load_r;
  logic [31:0]        l_val_r;
  logic               lo_r;
  logic [23:0]        wake_r;
  logic [23:0]        rdata_r;
  logic               nack_r;
  logic [31:0]        low_cnt_r;
  logic [31:0]        hi_cnt_r;
  logic               scl_s;
  logic               sda_s;
  logic               q_zero;
  logic               q_load;
  logic               l_zero;
  logic               adv;
  logic               is_stop;
  logic               last_bit;
  logic               wr_ok;
  logic               ctrl_go;
  logic               nack_ev;
  logic               rx_done;
  logic               busy;

  wts_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .din      (scl_level),
    .dout     (scl_s)
  );

  wts_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .din      (sda_level),
    .dout     (sda_s)
  );

  wts_cnt #(.W(wts_pkg::QTR_W)) u_qtr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .load     (q_load),
    .load_val (wts_pkg::QTR_W'(QTR_CYC)),
    .zero     (q_zero)
  );

  wts_cnt #(.W(32)) u_long (
    .core_clk (core_clk),
    .resetn   (resetn),
    .load     (l_load_r),
    .load_val (l_val_r),
    .zero     (l_zero)
  );

  // a released clock line is only trusted once the synced level is high
  assign adv      = q_zero && (scl_oe || scl_s);
  assign q_load   = (st_r == S_FETCH) || adv;
  assign is_stop  = (cur_r.act == wts_pkg::WTS_A_STOP);
  assign last_bit = adv && (ph_r == 2'd3) && (bit_cnt_r == 4'd8);
  assign nxt_step = step_of(cmd_r, step_r, wake_r);
  assign busy     = (st_r != S_IDLE);
  assign wr_ok    = avs_write && !avs_waitrequest;
  assign cmd_new  = wts_pkg::wts_cmd_t'(avs_writedata[2:0]);
  assign nack_ev  = (st_r == S_BIT) && last_bit && (cur_r.act == wts_pkg::WTS_A_TX) && ack_bit_r;
  assign rx_done  = (st_r == S_BIT) && last_bit && cmd_r != wts_pkg::WTS_C_RECOV
                    && (cur_r.act == wts_pkg::WTS_A_RXA || cur_r.act == wts_pkg::WTS_A_RXN);

  // a wake-up read is only meaningful with timer-clear high
  assign ctrl_go = wr_ok && (avs_address == wts_pkg::OFF_CTRL) && !busy
                   && cmd_new != wts_pkg::WTS_C_NONE && avs_writedata[2:0] <= 3'h5
                   && (cmd_new != wts_pkg::WTS_C_RDWAKE || tclr_n);

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      st_r        <= S_BOOT;
      cmd_r       <= wts_pkg::WTS_C_RSTPULSE;
      cur_r       <= '{wts_pkg::WTS_A_END, 8'h00};
      step_r      <= 4'h0;
      bit_cnt_r   <= 4'h0;
      ph_r        <= 2'h0;
      sh_r        <= 8'hFF;
      ack_bit_r   <= 1'b0;
      nack_pend_r <= 1'b0;
      init_pend_r <= 1'b1;
      scl_oe      <= 1'b0;
      sda_oe      <= 1'b0;
      tclr_n      <= 1'b0;
      l_load_r    <= 1'b0;
      l_val_r     <= 32'h0;
    end
    else
    begin
      l_load_r <= 1'b0;
      case (st_r)
        S_BOOT:
        begin
          tclr_n   <= 1'b0;
          l_load_r <= 1'b1;
          l_val_r  <= 32'(RST_LOW_CYC);
          st_r     <= S_RSTLOW;
        end
        S_RSTLOW:
          if (l_zero && !l_load_r)
          begin
            tclr_n   <= 1'b1;
            l_load_r <= 1'b1;
            l_val_r  <= 32'(SETTLE_CYC);
            st_r     <= S_SETTLE;
          end
        S_SETTLE:
          if (l_zero && !l_load_r)
          begin
            // power-up ends with a recovery pass so a stuck data line is freed
            if (init_pend_r)
            begin
              init_pend_r <= 1'b0;
              cmd_r       <= wts_pkg::WTS_C_RECOV;
              step_r      <= 4'h0;
              st_r        <= S_FETCH;
            end
            else
              st_r <= S_IDLE;
          end
        S_IDLE:
          if (ctrl_go)
          begin
            cmd_r       <= cmd_new;
            step_r      <= 4'h0;
            nack_pend_r <= 1'b0;
            st_r        <= (cmd_new == wts_pkg::WTS_C_RSTPULSE) ? S_BOOT : S_FETCH;
          end
        S_FETCH:
        begin
          cur_r     <= nxt_step;
          sh_r      <= nxt_step.dat;
          ph_r      <= 2'h0;
          bit_cnt_r <= 4'h0;
          ack_bit_r <= 1'b0;
          case (nxt_step.act)
            wts_pkg::WTS_A_END:   st_r <= S_IDLE;
            wts_pkg::WTS_A_START: st_r <= S_COND;
            wts_pkg::WTS_A_STOP:  st_r <= S_COND;
            default:              st_r <= S_BIT;
          endcase
        end
        S_COND:
          if (adv)
          begin
            ph_r <= ph_r + 2'd1;
            case (ph_r)
              2'd0: sda_oe <= is_stop;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= !is_stop;
              default:
              begin
                scl_oe <= !is_stop;
                if (is_stop && nack_pend_r)
                begin
                  l_load_r <= 1'b1;
                  l_val_r  <= 32'(RETRY_CYC);
                  st_r     <= S_HOLD;
                end
                else
                begin
                  step_r <= step_r + 4'd1;
                  st_r   <= S_FETCH;
                end
              end
            endcase
          end
        S_BIT:
          if (adv)
          begin
            ph_r <= ph_r + 2'd1;
            case (ph_r)
              2'd0:
                if (bit_cnt_r == 4'd8)
                  sda_oe <= (cur_r.act == wts_pkg::WTS_A_RXA);
                else
                  sda_oe <= (cur_r.act == wts_pkg::WTS_A_TX) && !sh_r[7];
              2'd1: scl_oe <= 1'b0;
              2'd2:
                if (bit_cnt_r == 4'd8)
                  ack_bit_r <= sda_s;
                else if (cur_r.act != wts_pkg::WTS_A_TX)
                  sh_r <= {sh_r[6:0], sda_s};
              default:
              begin
                scl_oe <= 1'b1;
                if (cur_r.act == wts_pkg::WTS_A_TX)
                  sh_r <= {sh_r[6:0], 1'b1};
                if (bit_cnt_r != 4'd8)
                  bit_cnt_r <= bit_cnt_r + 4'd1;
                else if (nack_ev)
                begin
                  // refused byte: stop at once, never finish a partial group
                  nack_pend_r <= 1'b1;
                  cur_r.act   <= wts_pkg::WTS_A_STOP;
                  st_r        <= S_COND;
                end
                else
                begin
                  step_r <= step_r + 4'd1;
                  st_r   <= S_FETCH;
                end
              end
            endcase
          end
        S_HOLD:
          if (l_zero && !l_load_r)
            st_r <= S_IDLE;
        default: st_r <= S_BOOT;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      wake_r          <= wts_pkg::WAKE_RST;
    end
    else
    begin
      if ((avs_read || avs_write) && avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        case (avs_address)
          wts_pkg::OFF_CTRL:   avs_readdata <= {29'h0, cmd_r};
          wts_pkg::OFF_WAKE:   avs_readdata <= {8'h0, wake_r};
          wts_pkg::OFF_RDATA:  avs_readdata <= {8'h0, rdata_r};
          wts_pkg::OFF_STATUS: avs_readdata <= {28'h0, init_pend_r, tclr_n, nack_r, busy};
          default:             avs_readdata <= 32'h0;
        endcase
      end
      else
        avs_waitrequest <= 1'b1;
      // held while busy so a group in flight never mixes old and new bytes
      if (wr_ok && avs_address == wts_pkg::OFF_WAKE && !busy)
        wake_r <= avs_writedata[23:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      nack_r <= 1'b0;
    else if (nack_ev)
      nack_r <= 1'b1;
    else if (wr_ok && avs_address == wts_pkg::OFF_STATUS && avs_writedata[wts_pkg::ST_NACK])
      nack_r <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      rdata_r <= 24'h0;
    else if (ctrl_go)
      rdata_r <= 24'h0;
    else if (rx_done)
      rdata_r <= {rdata_r[15:0], sh_r};
  end

  // open-drain: drive value is always low, only the enables move
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      lo_r <= 1'b0;
    else
      lo_r <= 1'b0;
  end

  assign scl_drive = lo_r;
  assign sda_drive = lo_r;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      low_cnt_r <= 32'h0;
      hi_cnt_r  <= 32'h0;
    end
    else
    begin
      low_cnt_r <= tclr_n ? 32'h0 : low_cnt_r + ((low_cnt_r != 32'hFFFFFFFF) ? 32'h1 : 32'h0);
      hi_cnt_r  <= !tclr_n ? 32'h0 : hi_cnt_r + ((hi_cnt_r != 32'hFFFFFFFF) ? 32'h1 : 32'h0);
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_tclr_rise;
    $rose(tclr_n);
  endsequence

  sequence s_refused;
    nack_ev ##1 (st_r == S_COND && cur_r.act == wts_pkg::WTS_A_STOP);
  endsequence

  addr_write_a: assert property (
    (st_r == S_BIT && step_r == 4'd1 && bit_cnt_r == 4'd0 && ph_r == 2'd0
     && (cmd_r == wts_pkg::WTS_C_WRWAKE || cmd_r == wts_pkg::WTS_C_RDWAKE))
    |-> sh_r == wts_pkg::ADDR_WR)
    else $error("write address byte wrong");

  ptr_write_a: assert property (
    (st_r == S_BIT && step_r == 4'd2 && bit_cnt_r == 4'd0 && cmd_r == wts_pkg::WTS_C_WRWAKE)
    |-> sh_r == wts_pkg::PTR_WR)
    else $error("wake-up write pointer wrong");

  ptr_dummy_a: assert property (
    (st_r == S_BIT && step_r == 4'd2 && bit_cnt_r == 4'd0 && cmd_r == wts_pkg::WTS_C_RDWAKE)
    |-> sh_r == wts_pkg::PTR_RD)
    else $error("dummy write pointer wrong");

  read_addr_a: assert property (
    (st_r == S_BIT && step_r == 4'd4 && bit_cnt_r == 4'd0 && cmd_r == wts_pkg::WTS_C_RDWAKE)
    |-> sh_r == wts_pkg::ADDR_RD)
    else $error("read address after restart wrong");

  no_mid_stop_a: assert property (
    (cmd_r == wts_pkg::WTS_C_RDWAKE && st_r == S_COND && is_stop)
    |-> (step_r == 4'd8 || nack_pend_r))
    else $error("stop sent inside wake-up read");

  last_nack_a: assert property (
    (st_r == S_BIT && cur_r.act == wts_pkg::WTS_A_RXN && bit_cnt_r == 4'd8 && ph_r == 2'd1)
    |-> !sda_oe)
    else $error("last read byte was acknowledged");

  recov_free_a: assert property (
    // the start leaves data low until the first bit phase releases it
    (cmd_r == wts_pkg::WTS_C_RECOV && st_r == S_BIT && (ph_r != 2'd0 || bit_cnt_r != 4'd0))
    |-> (!sda_oe && cur_r.act == wts_pkg::WTS_A_RXN))
    else $error("data line driven during recovery clocks");

  rst_hold_a: assert property (
    s_tclr_rise |-> low_cnt_r >= 32'(RST_LOW_CYC))
    else $error("timer-clear low too short");

  settle_gap_a: assert property (
    (st_r == S_FETCH && step_r == 4'd0) |-> (tclr_n && hi_cnt_r >= 32'(SETTLE_CYC)))
    else $error("access too soon after timer-clear release");

  refuse_stop_a: assert property (
    nack_ev |-> s_refused)
    else $error("refused byte not followed by stop");

  bus_answer_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule

// ===== wts_dev_model.sv
`timescale 1ns/1ps
module wts_dev_model #(
  parameter int SMP = 8
)
(
  input  wire logic core_clk,
  input  wire logic osc_run,
  input  wire logic tclr_n,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  logic [23:0] wake_r = 24'h000000;
  logic [23:0] tim_r  = 24'h000000;
  logic [23:0] snap   = 24'h000000;
  logic [7:0]  sh     = 8'h00;
  logic [7:0]  tx     = 8'h00;
  logic [2:0]  smp    = 3'h0;
  logic        deb    = 1'b0;
  logic        act    = 1'b0;
  logic        rd     = 1'b0;
  logic        ptr    = 1'b0;
  logic        ok     = 1'b1;
  logic        wsel   = 1'b0;
  logic        kick   = 1'b0;
  int          bit_n  = 0;
  int          byte_n = 0;
  int          div    = 0;
  initial sda_oe = 1'b0;
  // oscillation only starts while timer-clear is held low, then keeps running
  always @(posedge core_clk)
    if (osc_run && (kick || !tclr_n))
    begin
      kick = 1'b1;
      div = (div + 1) % SMP;
      if (div == 0)
      begin
        smp = {smp[1:0], tclr_n};
        if (&smp) deb = 1'b1;
        if (~|smp) deb = 1'b0;
        tim_r = deb ? tim_r + 24'h000001 : 24'h000000;
      end
    end
  always @(negedge sda)
    if (scl && !sda_oe)
    begin
      act = 1'b1;
      bit_n = 0;
      byte_n = 0;
      rd = 1'b0;
    end
  always @(posedge sda)
    if (scl && !sda_oe)
    begin
      act = 1'b0;
      ptr = 1'b0;
    end
  always @(posedge scl)
    if (act)
    begin
      if (bit_n < 8) sh = {sh[6:0], sda};
      if (bit_n == 8 && rd && byte_n > 0 && sda) act = 1'b0;
      bit_n = bit_n + 1;
    end
  always @(negedge scl)
    if (act)
    begin
      if (bit_n == 9)
      begin
        bit_n = 0;
        byte_n = byte_n + 1;
        if (!ok) act = 1'b0;
      end
      if (bit_n == 8 && (byte_n == 0 || !rd))
      begin
        if (byte_n == 0)
        begin
          rd = sh[0];
          ok = (sh[7:1] == 7'b0110010);
          snap = (ptr && tclr_n) ? wake_r : tim_r;
        end
        else if (byte_n == 1)
        begin
          ptr = sh[0] && !sh[7];
          wsel = sh[7];
          ok = sh[0] && (deb || !sh[7]);
        end
        else
        begin
          ok = deb && wsel;
          if (ok) wake_r = {wake_r[15:0], sh};
          if (ok && byte_n == 4) tim_r = 24'h000000;
        end
        sda_oe = ok;
      end
      else if (act && rd && byte_n > 0 && bit_n < 8)
      begin
        if (bit_n == 0) tx = (byte_n > 3) ? 8'hFF : 8'(snap >> (8 * (3 - byte_n)));
        sda_oe = !tx[3'(7 - bit_n)];
      end
      else
        sda_oe = 1'b0;
    end
endmodule

// ===== wts_host_tb_top.sv
`timescale 1ns/1ps
module wts_host_tb_top;
  typedef struct packed {
    logic        wr;
    logic [3:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } wts_row_t;
  logic        core_clk      = 1'b0;
  logic        resetn        = 1'b0;
  logic [3:0]  avs_address   = 4'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic        osc_run       = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        scl_oe;
  logic        sda_oe;
  logic        dev_oe;
  logic        tclr_n;
  logic        scl;
  logic        sda;
  logic        scl_drv;
  logic        sda_drv;
  logic [31:0] q;
  int          failures      = 0;
  int          num_checks    = 0;
  wts_row_t    rows [7];
  always #4 core_clk = ~core_clk;
  assign scl = (scl_oe === 1'b1) ? scl_drv : 1'b1;
  assign sda = ((sda_oe === 1'b1) ? sda_drv : 1'b1) & ((dev_oe === 1'b1) ? 1'b0 : 1'b1);
  wts_host #(.RST_LOW_CYC(40), .SETTLE_CYC(30), .RETRY_CYC(30), .QTR_CYC(16)) uut (
    .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_level(scl), .scl_drive(scl_drv), .scl_oe(scl_oe),
    .sda_level(sda), .sda_drive(sda_drv), .sda_oe(sda_oe), .tclr_n(tclr_n));
  wts_dev_model #(.SMP(8)) dev (.core_clk(core_clk), .osc_run(osc_run), .tclr_n(tclr_n),
    .scl(scl), .sda(sda), .sda_oe(dev_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low; one idle edge keeps drivers single per step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_idle();
    bus(1'b0, 4'hC, 32'h0);
    while (q[0] !== 1'b0) bus(1'b0, 4'hC, 32'h0);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge core_clk);
    failures++;
    results();
  end
  initial
  begin
    rows[0] = '{1'b1, 4'h4, 32'hFFABCDEF, 32'h0};
    rows[1] = '{1'b0, 4'h4, 32'h0, 32'h00ABCDEF};
    rows[2] = '{1'b1, 4'h6, 32'h12345678, 32'h0};
    rows[3] = '{1'b0, 4'h6, 32'h0, 32'h0};
    rows[4] = '{1'b0, 4'h4, 32'h0, 32'h00ABCDEF};
    rows[5] = '{1'b1, 4'h0, 32'h00000007, 32'h0};
    rows[6] = '{1'b0, 4'hC, 32'h0, 32'h00000004};
    repeat (8) @(posedge core_clk);
    chk({28'h0, avs_waitrequest, tclr_n, scl_oe, sda_oe}, 32'h8);
    resetn <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 4'hC, 32'h0);
    chk(q & 32'h1, 32'h1);
    wait_idle();
    chk(q, 32'h4);
    foreach (rows[i])
    begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(q, rows[i].e);
    end
    // oscillator still stopped: the device must refuse the wake-up pointer byte
    bus(1'b1, 4'h0, 32'h1);
    wait_idle();
    chk(q & 32'h2, 32'h2);
    bus(1'b1, 4'hC, 32'h2);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h4);
    osc_run <= 1'b1;
    bus(1'b1, 4'h0, 32'h5);
    repeat (4) @(posedge core_clk);
    chk({31'h0, tclr_n}, 32'h0);
    wait_idle();
    chk(q, 32'h4);
    bus(1'b1, 4'h0, 32'h1);
    wait_idle();
    chk(q, 32'h4);
    chk({8'h00, dev.wake_r}, 32'h00ABCDEF);
    bus(1'b1, 4'h0, 32'h2);
    wait_idle();
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h00ABCDEF);
    bus(1'b1, 4'h0, 32'h3);
    wait_idle();
    chk(q, 32'h4);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, {8'h00, dev.snap});
    chk({30'h0, scl_drv, sda_drv}, 32'h0);
    // reset in mid-run: timer-clear low again and the power-up recovery pending
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h9);
    results();
  end
endmodule
